// >>> hdl/csei_pkg.sv
// csei_pkg: register map, field positions and carrier types for the
// charger status, event flag and interrupt mask block.
// assumes an internal register port already decoded from the serial bus.
package csei_pkg;

    // register offsets
    localparam logic [7:0] ADDR_PIN_STATUS = 8'h04;
    localparam logic [7:0] ADDR_EVENT_A    = 8'h05;
    localparam logic [7:0] ADDR_EVENT_B    = 8'h06;
    localparam logic [7:0] ADDR_MASK_A     = 8'h07;
    localparam logic [7:0] ADDR_MASK_B     = 8'h08;

    // reset values
    localparam logic [7:0] EVENT_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET  = 8'h00;
    localparam logic [7:0] READ_IDLE   = 8'h00;

    // status field positions
    localparam int ST_EXT_PWR  = 0;
    localparam int ST_INPUT_OK = 1;
    localparam int ST_FULL_SPEED_DETECTED   = 2;
    localparam int ST_THERM_SD = 3;
    localparam int ST_CHG_EN   = 4;
    localparam int ST_STDB_EN  = 5;
    localparam int ST_ENUM_EN  = 6;
    localparam int ST_IDEF     = 7;

    // event a positions
    localparam int EA_TIMER    = 0;
    localparam int EA_THERMREG = 1;
    localparam int EA_CHGSTATE = 2;
    localparam int EA_BATT     = 3;
    localparam int EA_PIN_IN   = 4;
    localparam int EA_PIN_OUT  = 5;
    localparam int EA_RESERVED = 6;
    localparam int EA_ADAPTER  = 7;

    // event b positions
    localparam int EB_COLD     = 0;
    localparam int EB_WARM     = 1;
    localparam int EB_HOT      = 2;
    localparam int EB_BUS_OK   = 3;
    localparam int EB_ENUMFAIL = 4;
    localparam int EB_ILIM     = 5;
    localparam int EB_RESUME   = 6;
    localparam int EB_SUSPEND  = 7;

    localparam logic [7:0] MASK_A_WRITABLE = 8'hBF;

    // charger-side levels and pulses that feed the block
    typedef struct packed {
        logic       external_power_on_output;
        logic       input_ok_output;
        logic       full_speed_detected;
        logic       thermal_shutdown;
        logic       charge_enable_input;
        logic       standby_enable_input;
        logic       enumeration_enable_input;
        logic       default_input_current_input;
        logic [2:0] charger_state;
        logic       battery_present;
        logic [3:0] adapter_type_field;
        logic       bus_power_good;
        logic       timer_expired;
        logic       thermal_regulation;
        logic       cold_battery;
        logic       warm_battery;
        logic       hot_battery;
        logic       enumeration_failed;
        logic       current_limited;
        logic       bus_resume;
        logic       bus_suspend;
    } csei_hw_t;

    // register port request
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } csei_req_t;

    typedef struct packed {
        logic       thermal_shutdown_latch;
        logic [7:0] event_flags_a;
        logic [7:0] event_flags_b;
        logic [7:0] interrupt_mask_a;
        logic [7:0] interrupt_mask_b;
        logic [7:0] rdata;
        logic [3:0] prev_pins_in;
        logic [1:0] prev_pins_out;
        logic [2:0] prev_charger_state;
        logic       prev_battery;
        logic [3:0] prev_adapter;
        logic       prev_bus_ok;
        logic       primed;
    } csei_state_t;

endpackage : csei_pkg

// >>> hdl/csei_irq.sv
// csei_irq: status mirror, clear-on-read event flags, mask registers and
// the active-low interrupt request of the charger register map.
// assumes the serial bus front end hands over one-cycle read and write
// strobes with an address, and takes read data on the cycle after a read.
//
// Overview of operation
// - status bit 0 shows external power-on level, bit 1 input-ok level.
// - status bit 2 is one when full-speed is supported as well.
// - status bit 3 latches thermal shutdown; a status read or a reset clears it.
// - status bits 4..7 mirror charge, standby, enumeration, current inputs.
// - both event registers reset to zero and clear when read.
// - event a bit 0 on timer expiry, bit 1 on thermal regulation.
// - event a bit 2 when the charger state field changes.
// - event a bit 3 when battery presence changes.
// - event a bit 4 when the charge, standby, enumeration or current input changes.
// - event a bit 5 when input-ok or external power-on changes.
// - event a bit 7 on adapter type change; bit 6 reads zero.
// - event b bits 0..2 flag cold, warm and hot battery.
// - event b bit 3 when bus power-good changes.
// - event b bit 4 when self-enumeration fails.
// - event b bit 5 when the input current limit triggers.
// - event b bit 6 on bus resume, bit 7 on suspend entry.
// - mask a bit zero lets the matching event a flag pull interrupt low.
// - mask a resets to zero; bit 6 is reserved.
// - mask b gates event b flags in the same way.
`timescale 1ns/1ps

module csei_irq (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              sys_rst,
    // charger state
    input  wire csei_pkg::csei_hw_t hw,
    // register port
    input  wire csei_pkg::csei_req_t req,
    output logic [7:0]             read_data,
    // interrupt pin
    output logic                   interrupt_request_low
);

    csei_pkg::csei_state_t st;
    csei_pkg::csei_state_t next_st;

    logic [3:0] pins_in;
    logic [1:0] pins_out;
    logic [7:0] status_now;
    logic [7:0] ev_a_set;
    logic [7:0] ev_b_set;
    logic       access_ok;
    logic       rd_ok;
    logic       wr_ok;

    function automatic logic hit(input csei_pkg::csei_req_t r,
                                 input logic [7:0] a);
        hit = (r.addr == a);
    endfunction : hit

    assign pins_in  = {hw.default_input_current_input,
                       hw.enumeration_enable_input,
                       hw.standby_enable_input,
                       hw.charge_enable_input};
    assign pins_out = {hw.input_ok_output, hw.external_power_on_output};
    assign access_ok = hw.bus_power_good;
    assign rd_ok = req.rd && access_ok;
    assign wr_ok = req.wr && access_ok;

    always_comb begin
        status_now = 8'h00;
        status_now[csei_pkg::ST_EXT_PWR]  = hw.external_power_on_output;
        status_now[csei_pkg::ST_INPUT_OK] = hw.input_ok_output;
        status_now[csei_pkg::ST_FULL_SPEED_DETECTED]   = hw.full_speed_detected;
        status_now[csei_pkg::ST_THERM_SD] = st.thermal_shutdown_latch;
        status_now[csei_pkg::ST_IDEF:csei_pkg::ST_CHG_EN] = pins_in;
    end

    always_comb begin
        ev_a_set = 8'h00;
        ev_b_set = 8'h00;
        ev_a_set[csei_pkg::EA_TIMER]    = hw.timer_expired;
        ev_a_set[csei_pkg::EA_THERMREG] = hw.thermal_regulation;
        ev_a_set[csei_pkg::EA_CHGSTATE] = st.primed &&
            (hw.charger_state != st.prev_charger_state);
        ev_a_set[csei_pkg::EA_BATT] = st.primed &&
            (hw.battery_present != st.prev_battery);
        ev_a_set[csei_pkg::EA_PIN_IN] = st.primed &&
            (pins_in != st.prev_pins_in);
        ev_a_set[csei_pkg::EA_PIN_OUT] = st.primed &&
            (pins_out != st.prev_pins_out);
        ev_a_set[csei_pkg::EA_ADAPTER] = st.primed &&
            (hw.adapter_type_field != st.prev_adapter);
        ev_b_set[csei_pkg::EB_COLD]     = hw.cold_battery;
        ev_b_set[csei_pkg::EB_WARM]     = hw.warm_battery;
        ev_b_set[csei_pkg::EB_HOT]      = hw.hot_battery;
        ev_b_set[csei_pkg::EB_BUS_OK]   = st.primed &&
            (hw.bus_power_good != st.prev_bus_ok);
        ev_b_set[csei_pkg::EB_ENUMFAIL] = hw.enumeration_failed;
        ev_b_set[csei_pkg::EB_ILIM]     = hw.current_limited;
        ev_b_set[csei_pkg::EB_RESUME]   = hw.bus_resume;
        ev_b_set[csei_pkg::EB_SUSPEND]  = hw.bus_suspend;
    end

    always_comb begin
        next_st = st;
        next_st.prev_pins_in       = pins_in;
        next_st.prev_pins_out      = pins_out;
        next_st.prev_charger_state = hw.charger_state;
        next_st.prev_battery       = hw.battery_present;
        next_st.prev_adapter       = hw.adapter_type_field;
        next_st.prev_bus_ok        = hw.bus_power_good;
        next_st.primed             = 1'b1;
        next_st.rdata              = csei_pkg::READ_IDLE;
        // read data and clear-on-read; a same-cycle event survives the clear
        if (rd_ok) begin
            if (hit(req, csei_pkg::ADDR_PIN_STATUS)) begin
                next_st.rdata = status_now;
                next_st.thermal_shutdown_latch = 1'b0;
            end else if (hit(req, csei_pkg::ADDR_EVENT_A)) begin
                next_st.rdata = st.event_flags_a;
                next_st.event_flags_a = csei_pkg::EVENT_RESET;
            end else if (hit(req, csei_pkg::ADDR_EVENT_B)) begin
                next_st.rdata = st.event_flags_b;
                next_st.event_flags_b = csei_pkg::EVENT_RESET;
            end else if (hit(req, csei_pkg::ADDR_MASK_A)) begin
                next_st.rdata = st.interrupt_mask_a;
            end else if (hit(req, csei_pkg::ADDR_MASK_B)) begin
                next_st.rdata = st.interrupt_mask_b;
            end
        end
        if (hw.thermal_shutdown) begin
            next_st.thermal_shutdown_latch = 1'b1;
        end
        next_st.event_flags_a = (next_st.event_flags_a | ev_a_set)
                                & csei_pkg::MASK_A_WRITABLE;
        next_st.event_flags_b = next_st.event_flags_b | ev_b_set;
        if (wr_ok && hit(req, csei_pkg::ADDR_MASK_A)) begin
            next_st.interrupt_mask_a =
                req.wdata & csei_pkg::MASK_A_WRITABLE;
        end
        if (wr_ok && hit(req, csei_pkg::ADDR_MASK_B)) begin
            next_st.interrupt_mask_b = req.wdata;
        end
        if (!hw.bus_power_good) begin
            next_st.interrupt_mask_a = csei_pkg::MASK_RESET;
            next_st.interrupt_mask_b = csei_pkg::MASK_RESET;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st <= '0;
            st.event_flags_a    <= csei_pkg::EVENT_RESET;
            st.event_flags_b    <= csei_pkg::EVENT_RESET;
            st.interrupt_mask_a <= csei_pkg::MASK_RESET;
            st.interrupt_mask_b <= csei_pkg::MASK_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign read_data = st.rdata;
    // any set flag whose mask bit is zero holds the pin low
    assign interrupt_request_low =
        ~(|(st.event_flags_a & ~st.interrupt_mask_a) |
          |(st.event_flags_b & ~st.interrupt_mask_b));

    // checks on the register port, the flags and the pin
    ext_pwr_read_a: assert property (@(posedge clock)
        disable iff (sys_rst)
        rd_ok && hit(req, csei_pkg::ADDR_PIN_STATUS) |=>
        read_data[csei_pkg::ST_EXT_PWR] ==
            $past(hw.external_power_on_output))
        else $error("external power level bit wrong");
    input_ok_read_a: assert property (@(posedge clock)
        disable iff (sys_rst)
        rd_ok && hit(req, csei_pkg::ADDR_PIN_STATUS) |=>
        read_data[csei_pkg::ST_INPUT_OK] == $past(hw.input_ok_output))
        else $error("input ok level bit wrong");
    full_speed_detected_read_a: assert property (@(posedge clock)
        disable iff (sys_rst)
        rd_ok && hit(req, csei_pkg::ADDR_PIN_STATUS) |=>
        read_data[csei_pkg::ST_FULL_SPEED_DETECTED] == $past(hw.full_speed_detected))
        else $error("full speed bit wrong");
    therm_latch_a: assert property (@(posedge clock)
        disable iff (sys_rst)
        hw.thermal_shutdown ##1 !rd_ok [*3] |=>
        st.thermal_shutdown_latch)
        else $error("thermal shutdown latch lost");
    therm_read_a: assert property (@(posedge clock)
        disable iff (sys_rst)
        rd_ok && hit(req, csei_pkg::ADDR_PIN_STATUS) |=>
        read_data[csei_pkg::ST_THERM_SD] ==
            $past(st.thermal_shutdown_latch))
        else $error("thermal shutdown bit wrong");
    therm_clear_a: assert property (@(posedge clock)
        disable iff (sys_rst)
        rd_ok && hit(req, csei_pkg::ADDR_PIN_STATUS) &&
        !hw.thermal_shutdown |=> !st.thermal_shutdown_latch)
        else $error("thermal shutdown latch not cleared");
    pins_mirror_a: assert property (@(posedge clock)
        disable iff (sys_rst)
        rd_ok && hit(req, csei_pkg::ADDR_PIN_STATUS) |=>
        read_data[csei_pkg::ST_IDEF:csei_pkg::ST_CHG_EN] ==
            $past(pins_in))
        else $error("mirrored inputs wrong");
    ev_clear_a: assert property (@(posedge clock)
        disable iff (sys_rst)
        rd_ok && hit(req, csei_pkg::ADDR_EVENT_A) && ev_a_set == 8'h00 |=>
        st.event_flags_a == csei_pkg::EVENT_RESET)
        else $error("event a not cleared by read");
    evb_clear_a: assert property (@(posedge clock)
        disable iff (sys_rst)
        rd_ok && hit(req, csei_pkg::ADDR_EVENT_B) && ev_b_set == 8'h00 |=>
        st.event_flags_b == csei_pkg::EVENT_RESET)
        else $error("event b not cleared by read");
    ev_hold_a: assert property (@(posedge clock)
        disable iff (sys_rst)
        !(rd_ok && hit(req, csei_pkg::ADDR_EVENT_A)) |=>
        (st.event_flags_a & $past(st.event_flags_a)) ==
            $past(st.event_flags_a))
        else $error("event a flag lost without a read");
    ev_read_a: assert property (@(posedge clock)
        disable iff (sys_rst)
        rd_ok && hit(req, csei_pkg::ADDR_EVENT_A) |=>
        read_data == $past(st.event_flags_a))
        else $error("event a read data wrong");
    ev_reset_a: assert property (@(posedge clock)
        $fell(sys_rst) |->
        st.event_flags_a == csei_pkg::EVENT_RESET &&
        st.event_flags_b == csei_pkg::EVENT_RESET)
        else $error("event flags not reset");
    timer_set_a: assert property (@(posedge clock)
        disable iff (sys_rst)
        hw.timer_expired |=> st.event_flags_a[csei_pkg::EA_TIMER])
        else $error("timer flag missed");
    therm_reg_a: assert property (@(posedge clock)
        disable iff (sys_rst)
        hw.thermal_regulation |=> st.event_flags_a[csei_pkg::EA_THERMREG])
        else $error("thermal regulation flag missed");
    chg_state_a: assert property (@(posedge clock)
        disable iff (sys_rst)
        st.primed && $changed(hw.charger_state) |=>
        st.event_flags_a[csei_pkg::EA_CHGSTATE])
        else $error("charger state change missed");
    batt_chg_a: assert property (@(posedge clock)
        disable iff (sys_rst)
        st.primed && $changed(hw.battery_present) |=>
        st.event_flags_a[csei_pkg::EA_BATT])
        else $error("battery presence change missed");
    pins_chg_a: assert property (@(posedge clock)
        disable iff (sys_rst)
        st.primed && $changed(pins_in) |=>
        st.event_flags_a[csei_pkg::EA_PIN_IN])
        else $error("input change missed");
    pin_out_chg_a: assert property (@(posedge clock)
        disable iff (sys_rst)
        st.primed && $changed(pins_out) |=>
        st.event_flags_a[csei_pkg::EA_PIN_OUT])
        else $error("output level change missed");
    adapter_chg_a: assert property (@(posedge clock)
        disable iff (sys_rst)
        st.primed && $changed(hw.adapter_type_field) |=>
        st.event_flags_a[csei_pkg::EA_ADAPTER])
        else $error("adapter type change missed");
    rsvd_zero_a: assert property (@(posedge clock)
        disable iff (sys_rst)
        !st.event_flags_a[csei_pkg::EA_RESERVED] &&
        !st.interrupt_mask_a[csei_pkg::EA_RESERVED])
        else $error("reserved bit set");
    cold_set_a: assert property (@(posedge clock)
        disable iff (sys_rst)
        hw.cold_battery |=> st.event_flags_b[csei_pkg::EB_COLD])
        else $error("cold battery flag missed");
    warm_set_a: assert property (@(posedge clock)
        disable iff (sys_rst)
        hw.warm_battery |=> st.event_flags_b[csei_pkg::EB_WARM])
        else $error("warm battery flag missed");
    hot_set_a: assert property (@(posedge clock)
        disable iff (sys_rst)
        hw.hot_battery |=> st.event_flags_b[csei_pkg::EB_HOT])
        else $error("hot battery flag missed");
    bus_ok_chg_a: assert property (@(posedge clock)
        disable iff (sys_rst)
        st.primed && $changed(hw.bus_power_good) |=>
        st.event_flags_b[csei_pkg::EB_BUS_OK])
        else $error("bus power change missed");
    enum_fail_a: assert property (@(posedge clock)
        disable iff (sys_rst)
        hw.enumeration_failed |=> st.event_flags_b[csei_pkg::EB_ENUMFAIL])
        else $error("enumeration failure flag missed");
    ilim_set_a: assert property (@(posedge clock)
        disable iff (sys_rst)
        hw.current_limited |=> st.event_flags_b[csei_pkg::EB_ILIM])
        else $error("current limit flag missed");
    resume_set_a: assert property (@(posedge clock)
        disable iff (sys_rst)
        hw.bus_resume |=> st.event_flags_b[csei_pkg::EB_RESUME])
        else $error("resume flag missed");
    suspend_set_a: assert property (@(posedge clock)
        disable iff (sys_rst)
        hw.bus_suspend |=> st.event_flags_b[csei_pkg::EB_SUSPEND])
        else $error("suspend flag missed");
    mask_gate_a: assert property (@(posedge clock)
        disable iff (sys_rst)
        |(st.event_flags_a & ~st.interrupt_mask_a)
        |-> !interrupt_request_low)
        else $error("unmasked event a flag left pin high");
    irq_masked_a: assert property (@(posedge clock)
        disable iff (sys_rst)
        (st.event_flags_a & ~st.interrupt_mask_a) == 8'h00 &&
        (st.event_flags_b & ~st.interrupt_mask_b) == 8'h00 |->
        interrupt_request_low)
        else $error("interrupt without an unmasked flag");
    mask_reset_a: assert property (@(posedge clock)
        $fell(sys_rst) |-> st.interrupt_mask_a == csei_pkg::MASK_RESET)
        else $error("mask a not reset");
    mask_write_a: assert property (@(posedge clock)
        disable iff (sys_rst)
        wr_ok && hit(req, csei_pkg::ADDR_MASK_A) |=>
        st.interrupt_mask_a ==
            ($past(req.wdata) & csei_pkg::MASK_A_WRITABLE))
        else $error("mask a write lost");
    maskb_write_a: assert property (@(posedge clock)
        disable iff (sys_rst)
        wr_ok && hit(req, csei_pkg::ADDR_MASK_B) |=>
        st.interrupt_mask_b == $past(req.wdata))
        else $error("mask b write lost");
    maskb_gate_a: assert property (@(posedge clock)
        disable iff (sys_rst)
        |(st.event_flags_b & ~st.interrupt_mask_b)
        |-> !interrupt_request_low)
        else $error("unmasked event b flag left pin high");
    irq_pin_a: assert property (@(posedge clock)
        disable iff (sys_rst)
        hw.current_limited && !st.interrupt_mask_b[csei_pkg::EB_ILIM] &&
        hw.bus_power_good && !wr_ok |=> !interrupt_request_low)
        else $error("interrupt not raised");
    irq_release_a: assert property (@(posedge clock)
        disable iff (sys_rst)
        rd_ok && hit(req, csei_pkg::ADDR_EVENT_A) && ev_a_set == 8'h00 &&
        st.event_flags_b == 8'h00 && ev_b_set == 8'h00 |=>
        interrupt_request_low)
        else $error("interrupt not released");
    mask_drop_a: assert property (@(posedge clock)
        disable iff (sys_rst)
        !hw.bus_power_good |=> st.interrupt_mask_a == 8'h00 &&
        st.interrupt_mask_b == 8'h00)
        else $error("masks kept with bus power bad");
    refused_rd_a: assert property (@(posedge clock)
        disable iff (sys_rst)
        req.rd && !hw.bus_power_good |=> read_data == csei_pkg::READ_IDLE)
        else $error("read answered with bus power bad");

endmodule : csei_irq

// >>> tb/csei_host.sv
// csei_host: host processor model on the decoded register port.
// assumes the testbench calls its tasks one at a time, off the rising edge.
`timescale 1ns/1ps

module csei_host (
    // clock
    input  wire logic           clock,
    // register port
    input  wire logic [7:0]     read_data,
    output csei_pkg::csei_req_t req,
    // interrupt pin
    input  wire logic           interrupt_request_low
);
    initial req = '{rd: 1'b0, wr: 1'b0, addr: 8'h00, wdata: 8'h00};

    // one strobe cycle; released address and data show the inverse value
    task automatic access(input logic rd, input logic [7:0] a,
                          input logic [7:0] w, output logic [7:0] d);
        @(negedge clock);
        req = '{rd: rd, wr: ~rd, addr: a, wdata: w};
        @(negedge clock);
        d = read_data;
        req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~w};
    endtask : access

    // both event registers are read to find and clear the causes
    task automatic service(output logic [7:0] ea, output logic [7:0] eb);
        access(1'b1, csei_pkg::ADDR_EVENT_A, 8'h00, ea);
        access(1'b1, csei_pkg::ADDR_EVENT_B, 8'h00, eb);
    endtask : service
endmodule : csei_host

// >>> tb/tb_csei_irq.sv
// tb_csei_irq: self-checking bench for the status, event and mask block.
// assumes csei_pkg is compiled first and the host model drives the port.
`timescale 1ns/1ps
`define CHK(g, e) check(g, e)

module tb_csei_irq;
    logic                clock = 1'b0;
    logic                sys_rst = 1'b1;
    csei_pkg::csei_hw_t  hw;
    csei_pkg::csei_req_t req;
    logic [7:0]          read_data;
    logic                interrupt_request_low;
    logic [7:0]          ea;
    logic [7:0]          eb;
    logic [7:0]          d;
    int                  errors = 0;
    int                  tests_run = 0;
    int                  cycles = 0;

    always #25 clock = ~clock;

    csei_irq u_csei_irq (.clock(clock), .sys_rst(sys_rst), .hw(hw),
        .req(req), .read_data(read_data),
        .interrupt_request_low(interrupt_request_low));
    csei_host u_csei_host (.clock(clock), .read_data(read_data),
        .req(req), .interrupt_request_low(interrupt_request_low));

    task automatic check(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t ns: got %h, want %h", $time, g, e);
        end
    endtask : check

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        u_csei_host.access(1'b1, a, 8'h00, v);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [7:0] w);
        logic [7:0] v;
        u_csei_host.access(1'b0, a, w, v);
    endtask : wr

    // drive the seven mirrored levels; bit 3 of p is not a level
    task automatic levels(input logic [7:0] p);
        @(negedge clock);
        {hw.default_input_current_input, hw.enumeration_enable_input,
         hw.standby_enable_input, hw.charge_enable_input,
         hw.full_speed_detected, hw.input_ok_output,
         hw.external_power_on_output} = {p[7:4], p[2:0]};
    endtask : levels

    // cause one event: 0..5 and 7 feed register a, 8..15 register b; 6 drives nothing
    task automatic fire(input int i);
        @(negedge clock);
        case (i)
            0: hw.timer_expired = 1'b1;
            1: hw.thermal_regulation = 1'b1;
            2: hw.charger_state = ~hw.charger_state;
            3: hw.battery_present = ~hw.battery_present;
            4: hw.standby_enable_input = ~hw.standby_enable_input;
            5: hw.input_ok_output = ~hw.input_ok_output;
            7: hw.adapter_type_field = ~hw.adapter_type_field;
            8: hw.cold_battery = 1'b1;
            9: hw.warm_battery = 1'b1;
            10: hw.hot_battery = 1'b1;
            11: hw.bus_power_good = 1'b0;
            12: hw.enumeration_failed = 1'b1;
            13: hw.current_limited = 1'b1;
            14: hw.bus_resume = 1'b1;
            15: hw.bus_suspend = 1'b1;
            default: ;
        endcase
        @(negedge clock);
        // pulses end and bus power is good again
        hw[9:0] = 10'h200;
    endtask : fire

    task automatic t_reset;
        `CHK({7'h00, interrupt_request_low}, 8'h01);
        rd(csei_pkg::ADDR_EVENT_A, d);
        `CHK(d, 8'h00);
        rd(csei_pkg::ADDR_EVENT_B, d);
        `CHK(d, 8'h00);
        rd(csei_pkg::ADDR_MASK_A, d);
        `CHK(d, 8'h00);
        $display("test reset values done");
    endtask : t_reset

    task automatic t_status;
        levels(8'hA5);
        rd(csei_pkg::ADDR_PIN_STATUS, d);
        `CHK(d, 8'hA5);
        @(negedge clock);
        `CHK(read_data, 8'h00);
        hw.thermal_shutdown = 1'b1;
        @(negedge clock);
        hw.thermal_shutdown = 1'b0;
        repeat (5) @(negedge clock);
        rd(csei_pkg::ADDR_PIN_STATUS, d);
        `CHK(d, 8'hAD);
        rd(csei_pkg::ADDR_PIN_STATUS, d);
        `CHK(d, 8'hA5);
        levels(8'h52);
        rd(csei_pkg::ADDR_PIN_STATUS, d);
        `CHK(d, 8'h52);
        $display("test status mirror done");
    endtask : t_status

    task automatic t_events;
        for (int i = 0; i < 16; i++) begin
            if (i == 6)
                continue;
            u_csei_host.service(ea, eb);
            fire(i);
            `CHK({7'h00, interrupt_request_low}, 8'h00);
            u_csei_host.service(ea, eb);
            `CHK(ea, (i < 8) ? 8'h01 << i : 8'h00);
            `CHK(eb, (i > 7) ? 8'h01 << (i - 8) : 8'h00);
            `CHK({7'h00, interrupt_request_low}, 8'h01);
        end
        $display("test event sources done");
    endtask : t_events

    task automatic t_mask;
        wr(csei_pkg::ADDR_MASK_A, 8'hFF);
        rd(csei_pkg::ADDR_MASK_A, d);
        `CHK(d, 8'hBF);
        fire(0);
        `CHK({7'h00, interrupt_request_low}, 8'h01);
        wr(csei_pkg::ADDR_MASK_B, 8'hFF);
        rd(csei_pkg::ADDR_MASK_B, d);
        `CHK(d, 8'hFF);
        fire(8);
        `CHK({7'h00, interrupt_request_low}, 8'h01);
        u_csei_host.service(ea, eb);
        `CHK(ea, 8'h01);
        `CHK(eb, 8'h01);
        wr(csei_pkg::ADDR_MASK_A, 8'h01);
        fire(1);
        `CHK({7'h00, interrupt_request_low}, 8'h00);
        u_csei_host.service(ea, eb);
        wr(csei_pkg::ADDR_EVENT_A, 8'hFF);
        rd(csei_pkg::ADDR_EVENT_A, d);
        `CHK(d, 8'h00);
        rd(8'h09, d);
        `CHK(d, 8'h00);
        @(negedge clock);
        hw.bus_power_good = 1'b0;
        rd(csei_pkg::ADDR_EVENT_B, d);
        `CHK(d, 8'h00);
        wr(csei_pkg::ADDR_MASK_A, 8'h80);
        hw.bus_power_good = 1'b1;
        rd(csei_pkg::ADDR_MASK_A, d);
        `CHK(d, 8'h00);
        rd(csei_pkg::ADDR_MASK_B, d);
        `CHK(d, 8'h00);
        u_csei_host.service(ea, eb);
        `CHK(eb, 8'h08);
        $display("test masks and refusals done");
    endtask : t_mask

    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up

    // the whole run needs well under a thousand cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            $display("unexpected at %0t ns: run did not finish", $time);
            wrap_up();
        end
    end

    initial begin
        hw = '0;
        hw.bus_power_good = 1'b1;
        repeat (20) @(negedge clock);
        sys_rst = 1'b0;
        repeat (2) @(negedge clock);
        t_reset();
        t_status();
        t_events();
        t_mask();
        wrap_up();
    end
endmodule : tb_csei_irq
